// ---- shtr_pkg.sv ----
// Shared constants and carriers for the structure health tracking block.
// Assumes a single 100 MHz core clock and Avalon-MM register access.
package shtr_pkg;

  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFF_THRESH = 8'h00;
  localparam logic [7:0] OFF_QUERY = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_VEC_LO = 8'h0c;
  localparam logic [7:0] OFF_VEC_HI = 8'h10;
  localparam logic [7:0] OFF_LAST_CHECK = 8'h14;
  localparam logic [7:0] OFF_PSW = 8'h18;
  localparam logic [7:0] OFF_LOG_TRACK = 8'h1c;

  // ----------------------------------------
  // Field layouts and reset values
  // ----------------------------------------
  localparam int THR_W = 8;
  localparam logic [THR_W-1:0] THRESH_RST = 8'h04;
  localparam int PSW_DAMAGE_BIT = 0;
  localparam int GROUP_W = 4;
  localparam int NUM_GROUPS = 4;
  localparam int TRACK_W = GROUP_W * NUM_GROUPS;
  localparam int VEC_W = 64;
  localparam int LEVEL_W = 2;
  localparam int ENTRY_W = 4;
  localparam int REPEAT_W = 2;
  localparam logic [REPEAT_W-1:0] REPEAT_LIMIT = 2'h2;

  // ----------------------------------------
  // Health codes
  // ----------------------------------------
  localparam logic [1:0] HLTH_NONE = 2'h0;
  localparam logic [1:0] HLTH_NORMAL = 2'h1;
  localparam logic [1:0] HLTH_CAUTION = 2'h2;
  localparam logic [1:0] HLTH_RSVD = 2'h3;

  // ----------------------------------------
  // Query status codes, sign-extended to the bus word
  // ----------------------------------------
  localparam logic [31:0] STAT_OK = 32'h0000_0000;
  localparam logic [31:0] STAT_UNIMPL = 32'hffff_ffff;
  localparam logic [31:0] STAT_BADARG = 32'hffff_fffe;
  localparam logic [31:0] STAT_ERROR = 32'hffff_fffd;

  // ----------------------------------------
  // Structure kinds
  // ----------------------------------------
  typedef enum logic [1:0] {
    KIND_ICACHE = 2'b00,
    KIND_DCACHE = 2'b01,
    KIND_ITLB = 2'b10,
    KIND_DTLB = 2'b11
  } shtr_kind_t;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    shtr_kind_t kind;
    logic [LEVEL_W-1:0] level;
    logic [ENTRY_W-1:0] entry;
  } shtr_event_t;

  typedef struct packed {
    logic [1:0] hlth;
    logic [5:0] rsvd;
    logic [19:0] zero;
    shtr_kind_t kind;
    logic [LEVEL_W-1:0] level;
  } shtr_check_t;

  typedef struct packed {
    logic valid;
    shtr_check_t check;
    logic [TRACK_W-1:0] track;
  } shtr_log_t;

endpackage : shtr_pkg

// ---- shtr_entry_tracker.sv ----
// Per structure-level tracker of entries that needed repeated corrections.
// Assumes hit is a single-cycle strobe with a stable entry index.
`timescale 1ns/10ps
module shtr_entry_tracker #(
  parameter int ENTRIES = 16,
  parameter int CNT_W = 5
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Correction strobe
  input wire logic hit,
  input wire logic [shtr_pkg::ENTRY_W-1:0] entry,
  // Affected entry count
  output logic [CNT_W-1:0] affected
);

  logic [shtr_pkg::REPEAT_W-1:0] corr [ENTRIES];
  logic [shtr_pkg::REPEAT_W-1:0] next_corr [ENTRIES];
  logic [CNT_W-1:0] next_affected;

  // ----------------------------------------
  // Saturating per-entry correction count
  // ----------------------------------------
  always_comb begin
    next_corr = corr;
    next_affected = affected;
    if (hit && corr[entry] != shtr_pkg::REPEAT_LIMIT) begin
      next_corr[entry] = corr[entry] + 1'b1;
      if (next_corr[entry] == shtr_pkg::REPEAT_LIMIT) begin
        next_affected = affected + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < ENTRIES; i++) begin
        corr[i] <= '0;
      end
      affected <= '0;
    end else begin
      corr <= next_corr;
      affected <= next_affected;
    end
  end

endmodule : shtr_entry_tracker

// ---- shtr_core.sv ----
// Cache and TLB health tracking, check-word reporting and capability query.
// Assumes synchronous event inputs and an Avalon-MM master on the register port.
//
// Functional notes
// - The cache check word carries health in bits 31:30: 00 untracked, 01 normal, 10 cautionary, 11 reserved.
// - The TLB check word carries the same health code for the TLB type and level that reported.
// - A tracked structure reads normal while its affected entry count is at or below the threshold.
// - A tracked structure reads cautionary once its affected entry count exceeds the threshold.
// - Any cautionary report also sets the hardware-damage bit of the processor state word.
// - A query returns a 64-bit vector of the structure levels that are tracked.
// - A query ends with status 0 success, -1 unimplemented, -2 invalid argument or -3 error; the core never returns -3 (STAT_ERROR is unused).
// - Vector bits 3:0 flag the tracked instruction cache levels.
// - Vector bits 7:4 flag the tracked data or unified cache levels.
// - Vector bits 11:8 flag the tracked instruction TLB levels.
// - Vector bits 15:12 flag the tracked data or unified TLB levels.
// - In each group the lowest bit is the lowest level of that hierarchy.
// - Every corrected-event log also carries the tracking vector.
//
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/10ps
module shtr_core #(
  parameter logic [shtr_pkg::TRACK_W-1:0] TRACK_MASK = 16'h0033,
  parameter int ENTRIES = 16
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Corrected event input
  input wire shtr_pkg::shtr_event_t corr_event,
  // Reporting
  output shtr_pkg::shtr_check_t cache_check_word,
  output shtr_pkg::shtr_check_t tlb_check_word,
  output shtr_pkg::shtr_log_t error_log,
  output logic hw_damage
);

  localparam int NSTRUCT = shtr_pkg::TRACK_W;
  localparam int CNT_W = $clog2(ENTRIES + 1);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [3:0] struct_index(input shtr_pkg::shtr_kind_t kind,
                                              input logic [shtr_pkg::LEVEL_W-1:0] level);
    struct_index = {kind, level};
  endfunction : struct_index

  function automatic logic [1:0] health(input logic tracked, input logic [CNT_W-1:0] cnt,
                                        input logic [shtr_pkg::THR_W-1:0] thr);
    if (!tracked) begin
      health = shtr_pkg::HLTH_NONE;
    end else if (shtr_pkg::THR_W'(cnt) > thr) begin
      health = shtr_pkg::HLTH_CAUTION;
    end else begin
      health = shtr_pkg::HLTH_NORMAL;
    end
  endfunction : health

  function automatic logic is_tlb(input shtr_pkg::shtr_kind_t kind);
    is_tlb = (kind == shtr_pkg::KIND_ITLB) || (kind == shtr_pkg::KIND_DTLB);
  endfunction : is_tlb

  // ----------------------------------------
  // Trackers, one per structure level
  // ----------------------------------------
  logic [CNT_W-1:0] aff_cnt [NSTRUCT];

  for (genvar g = 0; g < NSTRUCT; g++) begin : g_trk
    logic trk_hit;
    assign trk_hit = corr_event.valid && TRACK_MASK[g]
                     && (struct_index(corr_event.kind, corr_event.level) == 4'(g));
    shtr_entry_tracker #(.ENTRIES(ENTRIES), .CNT_W(CNT_W)) u_trk (
      .mclk(mclk),
      .arst_n(arst_n),
      .hit(trk_hit),
      .entry(corr_event.entry),
      .affected(aff_cnt[g])
    );
  end

  // ----------------------------------------
  // Bus handshake: one wait state per access
  // ----------------------------------------
  logic ack;
  logic next_ack;
  logic bus_req;
  logic bus_take;

  assign bus_req = avs_read || avs_write;
  assign avs_waitrequest = bus_req && !ack;
  assign bus_take = bus_req && ack;

  // ----------------------------------------
  // Event pipeline and report state
  // ----------------------------------------
  shtr_pkg::shtr_event_t pend;
  shtr_pkg::shtr_event_t next_pend;
  shtr_pkg::shtr_check_t next_cache_check;
  shtr_pkg::shtr_check_t next_tlb_check;
  shtr_pkg::shtr_check_t last_check;
  shtr_pkg::shtr_check_t next_last_check;
  shtr_pkg::shtr_log_t next_log;
  logic [shtr_pkg::THR_W-1:0] threshold;
  logic [shtr_pkg::THR_W-1:0] next_threshold;
  logic [31:0] q_status;
  logic [31:0] next_q_status;
  logic [shtr_pkg::VEC_W-1:0] q_vec;
  logic [shtr_pkg::VEC_W-1:0] next_q_vec;
  logic next_hw_damage;
  logic [31:0] next_readdata;
  logic [1:0] pend_hlth;
  logic [CNT_W-1:0] pend_cnt;
  logic [3:0] pend_idx;
  logic [shtr_pkg::VEC_W-1:0] track_vec;

  // Groups follow kind order, level 0 in the low bit of each group
  assign track_vec = {{(shtr_pkg::VEC_W - shtr_pkg::TRACK_W){1'b0}}, TRACK_MASK};
  assign pend_idx = struct_index(pend.kind, pend.level);
  assign pend_cnt = aff_cnt[pend_idx];
  assign pend_hlth = health(TRACK_MASK[pend_idx], pend_cnt, threshold);

  always_comb begin
    next_ack = bus_req && !ack;
    next_pend = corr_event;
    next_threshold = threshold;
    next_q_status = q_status;
    next_q_vec = q_vec;
    next_hw_damage = hw_damage;
    next_cache_check = cache_check_word;
    next_tlb_check = tlb_check_word;
    next_last_check = last_check;
    next_log = error_log;
    next_log.valid = 1'b0;
    next_readdata = avs_readdata;

    // Check word for the structure that reported
    if (pend.valid) begin
      next_last_check = '0;
      next_last_check.hlth = pend_hlth;
      next_last_check.kind = pend.kind;
      next_last_check.level = pend.level;
      if (is_tlb(pend.kind)) begin
        next_tlb_check = next_last_check;
      end else begin
        next_cache_check = next_last_check;
      end
      next_log.valid = 1'b1;
      next_log.check = next_last_check;
      next_log.track = TRACK_MASK;
    end

    // Register writes
    if (bus_take && avs_write) begin
      case (avs_address)
        shtr_pkg::OFF_THRESH: begin
          if (avs_byteenable[0]) begin
            next_threshold = avs_writedata[shtr_pkg::THR_W-1:0];
          end
        end
        shtr_pkg::OFF_QUERY: begin
          if (avs_writedata != '0) begin
            next_q_status = shtr_pkg::STAT_BADARG;
            next_q_vec = '0;
          end else if (TRACK_MASK == '0) begin
            next_q_status = shtr_pkg::STAT_UNIMPL;
            next_q_vec = '0;
          end else begin
            next_q_status = shtr_pkg::STAT_OK;
            next_q_vec = track_vec;
          end
        end
        shtr_pkg::OFF_PSW: begin
          if (avs_byteenable[0] && avs_writedata[shtr_pkg::PSW_DAMAGE_BIT]) begin
            next_hw_damage = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    // Set wins over a same-cycle clear
    if (pend.valid && pend_hlth == shtr_pkg::HLTH_CAUTION) begin
      next_hw_damage = 1'b1;
    end

    // Register reads, captured as the wait state ends
    if (bus_req && !ack) begin
      case (avs_address)
        shtr_pkg::OFF_THRESH: next_readdata = 32'(threshold);
        shtr_pkg::OFF_STATUS: next_readdata = q_status;
        shtr_pkg::OFF_VEC_LO: next_readdata = q_vec[31:0];
        shtr_pkg::OFF_VEC_HI: next_readdata = q_vec[63:32];
        shtr_pkg::OFF_LAST_CHECK: next_readdata = last_check;
        shtr_pkg::OFF_PSW: next_readdata = 32'(hw_damage);
        shtr_pkg::OFF_LOG_TRACK: next_readdata = 32'(error_log.track);
        default: next_readdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      ack <= 1'b0;
      pend <= '0;
      threshold <= shtr_pkg::THRESH_RST;
      q_status <= shtr_pkg::STAT_OK;
      q_vec <= '0;
      hw_damage <= 1'b0;
      cache_check_word <= '0;
      tlb_check_word <= '0;
      last_check <= '0;
      error_log <= '0;
      avs_readdata <= '0;
    end else begin
      ack <= next_ack;
      pend <= next_pend;
      threshold <= next_threshold;
      q_status <= next_q_status;
      q_vec <= next_q_vec;
      hw_damage <= next_hw_damage;
      cache_check_word <= next_cache_check;
      tlb_check_word <= next_tlb_check;
      last_check <= next_last_check;
      error_log <= next_log;
      avs_readdata <= next_readdata;
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  a_hlth_no_rsvd: assert property (error_log.valid |-> error_log.check.hlth != shtr_pkg::HLTH_RSVD)
    else $error("Reserved health code reported");

  a_cache_word_load: assert property (corr_event.valid && !is_tlb(corr_event.kind)
    |-> ##2 cache_check_word.kind == $past(corr_event.kind, 2)
        && cache_check_word.hlth == error_log.check.hlth)
    else $error("Cache check word not loaded");

  a_tlb_word_load: assert property (corr_event.valid && is_tlb(corr_event.kind)
    |-> ##2 tlb_check_word.level == $past(corr_event.level, 2)
        && tlb_check_word.hlth == error_log.check.hlth)
    else $error("TLB check word not loaded");

  a_normal_at_thr: assert property (pend.valid && TRACK_MASK[pend_idx] && shtr_pkg::THR_W'(pend_cnt) <= threshold
    |=> error_log.check.hlth == shtr_pkg::HLTH_NORMAL)
    else $error("Normal health expected");

  a_caution_above: assert property (pend.valid && TRACK_MASK[pend_idx] && shtr_pkg::THR_W'(pend_cnt) > threshold
    |=> error_log.check.hlth == shtr_pkg::HLTH_CAUTION)
    else $error("Cautionary health expected");

  a_damage_set: assert property (error_log.valid && error_log.check.hlth == shtr_pkg::HLTH_CAUTION
    |-> hw_damage)
    else $error("Damage bit not set on caution");

  a_vec_read: assert property (bus_take && avs_read && avs_address == shtr_pkg::OFF_VEC_LO
    |-> avs_readdata == q_vec[31:0])
    else $error("Vector read mismatch");

  a_query_badarg: assert property (bus_take && avs_write && avs_address == shtr_pkg::OFF_QUERY
    && avs_writedata != '0 |=> q_status == shtr_pkg::STAT_BADARG && q_vec == '0)
    else $error("Invalid argument not reported");

  a_vec_icache: assert property (q_status == shtr_pkg::STAT_OK && q_vec != '0
    |-> q_vec[3:0] == TRACK_MASK[3:0])
    else $error("Instruction cache group wrong");

  a_vec_dcache: assert property (q_vec != '0 |-> q_vec[7:4] == TRACK_MASK[7:4])
    else $error("Data cache group wrong");

  a_vec_itlb: assert property (q_vec != '0 |-> q_vec[11:8] == TRACK_MASK[11:8])
    else $error("Instruction TLB group wrong");

  a_vec_dtlb: assert property (q_vec != '0 |-> q_vec[15:12] == TRACK_MASK[15:12])
    else $error("Data TLB group wrong");

  a_level_order: assert property (error_log.valid
    |-> (error_log.check.hlth != shtr_pkg::HLTH_NONE)
        == error_log.track[{error_log.check.kind, error_log.check.level}])
    else $error("Level bit order wrong");

  a_log_track: assert property ($rose(error_log.valid) |-> error_log.track == TRACK_MASK)
    else $error("Log lacks tracking vector");

  a_vec_upper: assert property (q_vec[63:16] == '0)
    else $error("Upper vector bits not zero");

  a_one_wait: assert property (bus_req && avs_waitrequest |=> !avs_waitrequest)
    else $error("More than one wait state");

  c_caution: cover property (error_log.valid && error_log.check.hlth == shtr_pkg::HLTH_CAUTION);
  c_query_ok: cover property (bus_take && avs_write && avs_address == shtr_pkg::OFF_QUERY
    ##1 q_status == shtr_pkg::STAT_OK);
  c_damage_clear: cover property (hw_damage ##1 !hw_damage);

endmodule : shtr_core

// ---- tb.sv ----
// Self-checking bench for the structure health tracking core.
// Assumes the shtr_pkg package is compiled first; one 100 MHz clock.
`timescale 1ns/10ps
module tb;
  // ----------------------------------------
  // Setup
  // ----------------------------------------
  localparam logic [15:0] MASK = 16'h8421;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  shtr_pkg::shtr_event_t corr_event = '0;
  shtr_pkg::shtr_check_t cache_check_word;
  shtr_pkg::shtr_check_t tlb_check_word;
  shtr_pkg::shtr_log_t error_log;
  logic hw_damage;
  int num_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int hits [16][16];
  int cnt [16];
  int thr = 4;
  logic dmg = 1'b0;
  logic [31:0] rd;
  shtr_pkg::shtr_check_t last;

  always #5 mclk = ~mclk;

  shtr_core #(.TRACK_MASK(MASK), .ENTRIES(16)) DUT (
    .mclk(mclk), .arst_n(arst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .corr_event(corr_event),
    .cache_check_word(cache_check_word), .tlb_check_word(tlb_check_word),
    .error_log(error_log), .hw_damage(hw_damage)
  );

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic close_out();
    if (num_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      num_errors++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= 4'hf;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      num_errors++;
      $display("BAD %0t bus access never answered", $time);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string msg);
    bus(1'b0, a, 32'h0);
    chk(rd, exp, msg);
  endtask : rd_chk

  task automatic ev(input logic [1:0] k, input logic [1:0] l, input logic [3:0] e);
    int idx;
    logic [1:0] h;
    idx = k * 4 + l;
    @(posedge mclk);
    corr_event <= '{valid: 1'b1, kind: shtr_pkg::shtr_kind_t'(k), level: l, entry: e};
    @(posedge mclk);
    corr_event.valid <= 1'b0;
    if (MASK[idx]) begin
      hits[idx][e]++;
      if (hits[idx][e] == 2) cnt[idx]++;
    end
    h = !MASK[idx] ? shtr_pkg::HLTH_NONE : (cnt[idx] > thr ? shtr_pkg::HLTH_CAUTION : shtr_pkg::HLTH_NORMAL);
    if (h == shtr_pkg::HLTH_CAUTION) dmg = 1'b1;
    last = '{hlth: h, rsvd: 6'h0, zero: 20'h0, kind: shtr_pkg::shtr_kind_t'(k), level: l};
    repeat (2) @(posedge mclk);
    chk(k[1] ? tlb_check_word : cache_check_word, last, "check word");
    chk(error_log.valid, 1'b1, "log valid");
    chk(error_log.check, last, "log check");
    chk(error_log.track, MASK, "log track");
    chk(hw_damage, dmg, "damage");
    @(posedge mclk);
    chk(error_log.valid, 1'b0, "log pulse");
  endtask : ev

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk(hw_damage, 1'b0, "damage at reset");
    rd_chk(shtr_pkg::OFF_THRESH, 32'h4, "thresh reset");
    rd_chk(shtr_pkg::OFF_STATUS, shtr_pkg::STAT_OK, "status reset");
    rd_chk(shtr_pkg::OFF_PSW, 32'h0, "psw reset");
    bus(1'b1, 8'h40, 32'hffff_ffff);
    rd_chk(8'h40, 32'h0, "unmapped");
  endtask : t_reset

  task automatic t_query();
    bus(1'b1, shtr_pkg::OFF_QUERY, 32'h1);
    rd_chk(shtr_pkg::OFF_STATUS, shtr_pkg::STAT_BADARG, "bad arg status");
    rd_chk(shtr_pkg::OFF_VEC_LO, 32'h0, "bad arg vector");
    bus(1'b1, shtr_pkg::OFF_QUERY, 32'h0);
    rd_chk(shtr_pkg::OFF_STATUS, shtr_pkg::STAT_OK, "ok status");
    rd_chk(shtr_pkg::OFF_VEC_LO, {16'h0, MASK}, "vector low");
    rd_chk(shtr_pkg::OFF_VEC_HI, 32'h0, "vector high");
  endtask : t_query

  task automatic t_health();
    thr = 1;
    bus(1'b1, shtr_pkg::OFF_THRESH, 32'h1);
    rd_chk(shtr_pkg::OFF_THRESH, 32'h1, "thresh write");
    ev(2'd0, 2'd0, 4'h3);
    ev(2'd0, 2'd1, 4'h3);
    ev(2'd1, 2'd1, 4'h0);
    ev(2'd2, 2'd0, 4'h5);
    ev(2'd2, 2'd0, 4'h5);
    ev(2'd2, 2'd2, 4'h1);
    ev(2'd3, 2'd3, 4'h0);
    ev(2'd3, 2'd3, 4'h0);
    ev(2'd3, 2'd3, 4'hf);
    ev(2'd3, 2'd3, 4'hf);
    rd_chk(shtr_pkg::OFF_LAST_CHECK, last, "last check");
    ev(2'd0, 2'd0, 4'h7);
    ev(2'd0, 2'd0, 4'h7);
    ev(2'd0, 2'd0, 4'h8);
    ev(2'd0, 2'd0, 4'h8);
    rd_chk(shtr_pkg::OFF_LAST_CHECK, last, "last cache check");
    rd_chk(shtr_pkg::OFF_LOG_TRACK, {16'h0, MASK}, "log track reg");
  endtask : t_health

  task automatic t_clear();
    rd_chk(shtr_pkg::OFF_PSW, 32'h1, "psw set");
    bus(1'b1, shtr_pkg::OFF_PSW, 32'h1);
    dmg = 1'b0;
    rd_chk(shtr_pkg::OFF_PSW, 32'h0, "psw cleared");
    chk(hw_damage, 1'b0, "damage cleared");
    ev(2'd1, 2'd1, 4'h2);
    ev(2'd3, 2'd3, 4'h9);
    rd_chk(shtr_pkg::OFF_PSW, 32'h1, "psw set again");
  endtask : t_clear

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    foreach (cnt[i]) cnt[i] = 0;
    foreach (hits[i, j]) hits[i][j] = 0;
    repeat (4) @(posedge mclk);
    arst_n <= 1'b1;
    t_reset();
    t_query();
    t_health();
    t_clear();
    close_out();
  end
endmodule : tb
